/* src/sysbus_master_pkg.sv */
package sysbus_master_pkg;

  // Clock rate and the millisecond time base derived from it.
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;

  // Boot-up delay limits and reset value, in milliseconds (3500 and 50000).
  localparam logic [15:0] BOOT_DELAY_MIN_MS = 16'h0dac;
  localparam logic [15:0] BOOT_DELAY_MAX_MS = 16'hc350;
  localparam logic [15:0] BOOT_DELAY_RST = 16'h0dac;

  // Synchronisation period (0 means off) and identifier after reset.
  localparam logic [15:0] SYNC_TIME_RST = 16'h0000;
  localparam logic [10:0] SYNC_ID_RST = 11'h000;
  localparam logic [10:0] SYNC_ID_PREDEF = 11'h080;

  // Emergency reaction settings.
  localparam logic [1:0] REACT_SHUTDOWN = 2'h0;
  localparam logic [1:0] REACT_WARNING = 2'h1;
  localparam logic [1:0] REACT_IGNORE = 2'h2;
  localparam logic [1:0] REACT_RST = 2'h0;

  // Network-management telegram layout and command specifiers.
  localparam logic [10:0] NMT_ID = 11'h000;
  localparam logic [3:0] NMT_DLC = 4'h2;
  localparam logic [3:0] SYNC_DLC = 4'h0;
  localparam logic [7:0] CS_START = 8'h01;
  localparam logic [7:0] CS_STOP = 8'h02;
  localparam logic [7:0] CS_PREOP = 8'h80;
  localparam logic [7:0] CS_RESET_NODE = 8'h81;
  localparam logic [7:0] CS_RESET_COMM = 8'h82;
  localparam logic [7:0] NODE_ALL = 8'h00;

  // Emergency identifiers are 128 plus a node ID of 1 to 63.
  localparam logic [10:0] EMCY_ID_FIRST = 11'h081;
  localparam logic [10:0] EMCY_ID_LAST = 11'h0bf;
  localparam logic [7:0] FAULT_CODE_HIGH = 8'h21;
  localparam int unsigned WARN_BUS_BIT = 13;

  // Register byte offsets.
  localparam logic [7:0] OFS_BOOT_DELAY = 8'h00;
  localparam logic [7:0] OFS_SYNC_TIME = 8'h04;
  localparam logic [7:0] OFS_SYNC_ID = 8'h08;
  localparam logic [7:0] OFS_REACTION = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_WARN = 8'h18;
  localparam logic [7:0] OFS_FAULT_CODE = 8'h1c;
  localparam logic [7:0] OFS_EMCY_NODE = 8'h20;
  localparam logic [7:0] OFS_EMCY_COUNT = 8'h24;

  // Field positions in the control and status registers.
  localparam int unsigned CTRL_ACK_BIT = 0;
  localparam int unsigned STAT_FAILURE_BIT = 0;
  localparam int unsigned STAT_FLAG_BIT = 1;
  localparam int unsigned STAT_STARTED_BIT = 2;

  typedef enum logic [1:0] {
    BOOT_WAIT_INIT,
    BOOT_DELAY,
    BOOT_RUN
  } boot_state_t;

endpackage

/* src/ms_tick.sv */
`timescale 1ns/1ps
// Free-running divider that emits a one-cycle pulse every CYCLES clocks.
module ms_tick #(
  parameter int unsigned CYCLES = 250000
) (
  input wire logic mclk,
  input wire logic rst,
  output logic tick
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;

  // Count up through the period and pulse in the cycle after its last.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
      if (cnt_q == LAST) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

endmodule

/* src/system_bus_master_control.sv */
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module system_bus_master_control #(
  parameter int unsigned TICK_CYCLES = sysbus_master_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Device status from the rest of the drive.
  input wire logic initDone,
  input wire logic localFault,
  // Frame transmit request towards the CAN controller.
  output logic txValid,
  input wire logic txReady,
  output logic [10:0] txId,
  output logic [3:0] txDlc,
  output logic [7:0] txData0,
  output logic [7:0] txData1,
  // Received frames from the CAN controller.
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [63:0] rxData,
  // Master status outputs.
  output logic failure,
  output logic bus_fault_flag,
  output logic [15:0] fault_code_word,
  output logic [15:0] warnStatus
);

  // Merges write data into an old register value under the byte strobes.
  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Holds a boot delay setting inside its legal range.
  function automatic logic [15:0] clampDelay(input logic [15:0] v);
    if (v < sysbus_master_pkg::BOOT_DELAY_MIN_MS) begin
      return sysbus_master_pkg::BOOT_DELAY_MIN_MS;
    end else if (v > sysbus_master_pkg::BOOT_DELAY_MAX_MS) begin
      return sysbus_master_pkg::BOOT_DELAY_MAX_MS;
    end
    return v;
  endfunction

  logic msTick;
  logic [15:0] bootDelay_q;
  logic [15:0] syncTime_q;
  logic [10:0] syncId_q;
  logic [1:0] reaction_q;
  sysbus_master_pkg::boot_state_t bootState_q;
  logic [15:0] bootMs_q;
  logic [15:0] syncMs_q;
  logic started_q;
  logic nmtPend_q;
  logic syncPend_q;
  logic nmtSet;
  logic syncSet;
  logic nmtTake;
  logic syncTake;
  logic txFree;
  logic wrAccess;
  logic setupPhase;
  logic ackWrite;
  logic mapped;
  logic [31:0] rdMux;
  logic [31:0] wrMerged;
  logic isEmcy;
  logic isRecovery;
  logic [5:0] emcyNode;
  logic faultEvent;
  logic shutdownEvent;
  logic failSet;
  logic flagSet;
  logic warnSet;
  logic [5:0] emcyNode_q;
  logic [15:0] emcyCount_q;
  logic [10:0] syncIdEff;

  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick(msTick)
  );

  // Bus phases; writes act on the access cycle, which is always ready.
  assign pready = 1'b1;
  assign setupPhase = psel & ~penable;
  assign wrAccess = psel & penable & pwrite;
  assign wrMerged = applyStrb(rdMux, pwdata, pstrb);
  assign ackWrite = wrAccess && (paddr == sysbus_master_pkg::OFS_CONTROL)
                    && pstrb[0] && pwdata[sysbus_master_pkg::CTRL_ACK_BIT];

  // Configuration registers; the boot delay is held inside its range on write.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootDelay_q <= sysbus_master_pkg::BOOT_DELAY_RST;
      syncTime_q <= sysbus_master_pkg::SYNC_TIME_RST;
      syncId_q <= sysbus_master_pkg::SYNC_ID_RST;
      reaction_q <= sysbus_master_pkg::REACT_RST;
    end else if (wrAccess) begin
      case (paddr)
        sysbus_master_pkg::OFS_BOOT_DELAY: begin
          bootDelay_q <= clampDelay(wrMerged[15:0]);
        end
        sysbus_master_pkg::OFS_SYNC_TIME: begin
          syncTime_q <= wrMerged[15:0];
        end
        sysbus_master_pkg::OFS_SYNC_ID: begin
          syncId_q <= wrMerged[10:0];
        end
        sysbus_master_pkg::OFS_REACTION: begin
          reaction_q <= wrMerged[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read decode of every mapped register; unmapped words read as zero.
  always_comb begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      sysbus_master_pkg::OFS_BOOT_DELAY: rdMux[15:0] = bootDelay_q;
      sysbus_master_pkg::OFS_SYNC_TIME: rdMux[15:0] = syncTime_q;
      sysbus_master_pkg::OFS_SYNC_ID: rdMux[10:0] = syncId_q;
      sysbus_master_pkg::OFS_REACTION: rdMux[1:0] = reaction_q;
      sysbus_master_pkg::OFS_CONTROL: rdMux = 32'h0000_0000;
      sysbus_master_pkg::OFS_STATUS: begin
        rdMux[sysbus_master_pkg::STAT_FAILURE_BIT] = failure;
        rdMux[sysbus_master_pkg::STAT_FLAG_BIT] = bus_fault_flag;
        rdMux[sysbus_master_pkg::STAT_STARTED_BIT] = started_q;
      end
      sysbus_master_pkg::OFS_WARN: rdMux[15:0] = warnStatus;
      sysbus_master_pkg::OFS_FAULT_CODE: rdMux[15:0] = fault_code_word;
      sysbus_master_pkg::OFS_EMCY_NODE: rdMux[5:0] = emcyNode_q;
      sysbus_master_pkg::OFS_EMCY_COUNT: rdMux[15:0] = emcyCount_q;
      default: mapped = 1'b0;
    endcase
  end

  // Read data and the error answer are captured in the setup cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr <= ~mapped;
    end
  end

  // Start sequencing: wait for init, run the delay, then repeat each delay.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootState_q <= sysbus_master_pkg::BOOT_WAIT_INIT;
      bootMs_q <= 16'h0000;
      started_q <= 1'b0;
    end else begin
      case (bootState_q)
        sysbus_master_pkg::BOOT_WAIT_INIT: begin
          bootMs_q <= 16'h0000;
          if (initDone) begin
            bootState_q <= sysbus_master_pkg::BOOT_DELAY;
          end
        end
        sysbus_master_pkg::BOOT_DELAY, sysbus_master_pkg::BOOT_RUN: begin
          if (msTick) begin
            if (bootMs_q + 16'h0001 >= bootDelay_q) begin
              bootMs_q <= 16'h0000;
              bootState_q <= sysbus_master_pkg::BOOT_RUN;
              started_q <= 1'b1;
            end else begin
              bootMs_q <= bootMs_q + 16'h0001;
            end
          end
        end
        default: begin
          bootState_q <= sysbus_master_pkg::BOOT_WAIT_INIT;
        end
      endcase
    end
  end

  // The broadcast start is due at each expiry of the delay.
  assign nmtSet = (bootState_q != sysbus_master_pkg::BOOT_WAIT_INIT) && msTick
                  && (bootMs_q + 16'h0001 >= bootDelay_q);

  // Sync period counter; a zero period keeps it idle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncMs_q <= 16'h0000;
    end else if (syncTime_q == 16'h0000) begin
      syncMs_q <= 16'h0000;
    end else if (msTick) begin
      if (syncMs_q + 16'h0001 >= syncTime_q) begin
        syncMs_q <= 16'h0000;
      end else begin
        syncMs_q <= syncMs_q + 16'h0001;
      end
    end
  end

  assign syncSet = (syncTime_q != 16'h0000) && msTick
                   && (syncMs_q + 16'h0001 >= syncTime_q);
  assign syncIdEff = (syncId_q == 11'h000) ? sysbus_master_pkg::SYNC_ID_PREDEF
                     : syncId_q;

  // Pending requests; a new due time wins over the take in the same cycle.
  assign txFree = ~txValid;
  assign nmtTake = txFree & nmtPend_q;
  assign syncTake = txFree & ~nmtPend_q & syncPend_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nmtPend_q <= 1'b0;
      syncPend_q <= 1'b0;
    end else begin
      nmtPend_q <= nmtSet | (nmtPend_q & ~nmtTake);
      syncPend_q <= syncSet | (syncPend_q & ~syncTake);
    end
  end

  // Transmit frame register; start commands take precedence over sync.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txId <= 11'h000;
      txDlc <= 4'h0;
      txData0 <= 8'h00;
      txData1 <= 8'h00;
    end else if (txValid) begin
      if (txReady) begin
        txValid <= 1'b0;
      end
    end else if (nmtTake) begin
      txValid <= 1'b1;
      txId <= sysbus_master_pkg::NMT_ID;
      txDlc <= sysbus_master_pkg::NMT_DLC;
      txData0 <= sysbus_master_pkg::CS_START;
      txData1 <= sysbus_master_pkg::NODE_ALL;
    end else if (syncTake) begin
      txValid <= 1'b1;
      txId <= syncIdEff;
      txDlc <= sysbus_master_pkg::SYNC_DLC;
      txData0 <= 8'h00;
      txData1 <= 8'h00;
    end
  end

  // Emergency frames from nodes 1 to 63; the node sits in the low id bits.
  assign isEmcy = rxValid && (rxId >= sysbus_master_pkg::EMCY_ID_FIRST)
                  && (rxId <= sysbus_master_pkg::EMCY_ID_LAST);
  assign emcyNode = rxId[5:0];
  assign isRecovery = (rxData == 64'h0000_0000_0000_0000);
  assign faultEvent = isEmcy && !isRecovery
                      && ((reaction_q == sysbus_master_pkg::REACT_SHUTDOWN)
                      || (reaction_q == sysbus_master_pkg::REACT_WARNING));
  assign shutdownEvent = faultEvent
                         && (reaction_q == sysbus_master_pkg::REACT_SHUTDOWN);
  assign failSet = shutdownEvent | localFault;
  assign flagSet = faultEvent | localFault;
  assign warnSet = faultEvent;

  // Failure state and fault code; only the first reporting node is kept.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      failure <= 1'b0;
      fault_code_word <= 16'h0000;
    end else begin
      failure <= failSet | (failure & ~ackWrite);
      if (shutdownEvent && !failure) begin
        fault_code_word <= {sysbus_master_pkg::FAULT_CODE_HIGH, 2'h0, emcyNode};
      end else if (ackWrite && !failSet) begin
        fault_code_word <= 16'h0000;
      end
    end
  end

  // Emergency flag and the bus warning bit; set wins over acknowledge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_fault_flag <= 1'b0;
      warnStatus <= 16'h0000;
    end else begin
      bus_fault_flag <= flagSet | (bus_fault_flag & ~ackWrite);
      warnStatus[sysbus_master_pkg::WARN_BUS_BIT] <= warnSet
        | (warnStatus[sysbus_master_pkg::WARN_BUS_BIT] & ~ackWrite);
    end
  end

  // Last non-ignored emergency source and a saturating count of fault events.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      emcyNode_q <= 6'h00;
      emcyCount_q <= 16'h0000;
    end else begin
      if (isEmcy && (reaction_q != sysbus_master_pkg::REACT_IGNORE)) begin
        emcyNode_q <= emcyNode;
      end
      if (faultEvent && (emcyCount_q != 16'hffff)) begin
        emcyCount_q <= emcyCount_q + 16'h0001;
      end
    end
  end

endmodule

/* testbench/system_bus_master_control_sva.sv */
`timescale 1ns/1ps
// Relates frames, faults and status at the master's ports.
module system_bus_master_control_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic initDone,
  input wire logic localFault,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [10:0] txId,
  input wire logic [3:0] txDlc,
  input wire logic [7:0] txData0,
  input wire logic [7:0] txData1,
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [63:0] rxData,
  input wire logic failure,
  input wire logic bus_fault_flag,
  input wire logic [15:0] fault_code_word,
  input wire logic [15:0] warnStatus
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic [10:0] idQ;
  // Keeps last cycle's identifier for the fault code.
  always_ff @(posedge mclk) idQ <= rxId;
  // Frame layout and hold.
  property p_start;
    txValid && txId == 11'h000 |-> txDlc == 4'h2 && txData0 == 8'h01
      && txData1 == 8'h00 && initDone;
  endproperty
  a_start: assert property (p_start) else $error("Bad start frame.");
  property p_sync;
    txValid && txId != 11'h000 |-> txDlc == 4'h0;
  endproperty
  a_sync: assert property (p_sync) else $error("Sync frame has data.");
  property p_hold;
    txValid && !txReady |=> txValid && $stable(txId) && $stable(txData0);
  endproperty
  a_hold: assert property (p_hold) else $error("Frame dropped.");
  // What may raise the fault and warning status.
  property p_code;
    $rose(failure) && $past(rxValid) && !$past(localFault)
      |-> fault_code_word == {8'h21, 2'h0, idQ[5:0]};
  endproperty
  a_code: assert property (p_code) else $error("Bad fault code.");
  property p_warn;
    $rose(warnStatus[13]) |-> bus_fault_flag && $past(rxValid);
  endproperty
  a_warn: assert property (p_warn) else $error("Bad warning.");
  property p_first;
    failure && $past(failure) |-> $stable(fault_code_word);
  endproperty
  a_first: assert property (p_first) else $error("Code overwritten.");
  property p_zero;
    rxValid && rxData == 64'h0 && !failure && !localFault |=> !failure;
  endproperty
  a_zero: assert property (p_zero) else $error("Recovery faulted.");
  property p_local;
    localFault |=> failure && bus_fault_flag;
  endproperty
  a_local: assert property (p_local) else $error("Own fault missed.");
  property p_cause;
    $rose(failure) |-> $past(rxValid) || $past(localFault);
  endproperty
  a_cause: assert property (p_cause) else $error("Failure uncaused.");
  c_start: cover property (txValid && txReady && txId == 11'h000);
  c_stall: cover property (txValid && !txReady);
  c_fail: cover property ($rose(failure));
endmodule

/* testbench/node_model.sv */
`timescale 1ns/1ps
// Stands for the CAN controller and one slave node beyond it.
module node_model #(
  parameter logic [7:0] NODE = 8'h05
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  input wire logic txValid,
  output logic txReady,
  input wire logic [10:0] txId,
  input wire logic [7:0] txData0,
  input wire logic [7:0] txData1,
  input wire logic emcyGo,
  input wire logic [5:0] emcyNode,
  input wire logic emcyZero,
  output logic rxValid,
  output logic [10:0] rxId,
  output logic [63:0] rxData
);
  int cyc, startCount, startGap, startAt, syncCount, syncGap, syncAt;
  logic [1:0] nodeState;
  logic [10:0] syncId;
  // The bench stalls acceptance to test holding.
  assign txReady = !stall;
  // Records frames, tracks node state and sends emergencies.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      nodeState <= 2'h0;  // Pre-operational after init.
      rxValid <= 1'h0;
      rxId <= 11'h2aa;
      rxData <= 64'h0;
    end else begin
      cyc <= cyc + 1;
      rxValid <= emcyGo;
      rxId <= emcyGo ? 11'h080 + {5'h0, emcyNode} : ~rxId;
      rxData <= !emcyGo ? ~rxData : emcyZero ? 64'h0 : 64'h1234_0000_0080_1000;
      if (txValid && txReady && txId == 11'h000) begin
        startCount <= startCount + 1;
        startGap <= cyc - startAt;
        startAt <= cyc;
        if (txData1 == 8'h00 || txData1 == NODE) begin
          case (txData0)
            8'h01: nodeState <= 2'h1;  // Operational passes process data.
            8'h02: nodeState <= 2'h2;  // Stopped passes nothing.
            default: nodeState <= 2'h0;
          endcase
        end
      end else if (txValid && txReady) begin
        syncCount <= syncCount + 1;
        syncGap <= cyc - syncAt;
        syncAt <= cyc;
        syncId <= txId;
      end
    end
  end
endmodule

/* testbench/test_system_bus_master_control.sv */
`timescale 1ns/1ps
// Runs register, frame and emergency cases against the bus master.
module test_system_bus_master_control;
  localparam int TICK = 4;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;
    logic [31:0] exp; logic e;} row_t;
  // A write first when wr is set, then a read compared with exp and e.
  row_t rows [9] = '{
    '{1'h0, 8'h00, 32'h0, 32'h0dac, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h0c, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h14, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h3c, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h00, 32'h64, 32'h0dac, 1'h0}, '{1'h1, 8'h00, 32'hea60, 32'hc350, 1'h0},
    '{1'h1, 8'h00, 32'h0dac, 32'h0dac, 1'h0}};
  logic mclk, pready, pslverr, txValid, txReady, rxValid, failure, bus_fault_flag, err;
  logic rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, initDone = 1'h0;
  logic localFault = 1'h0, stall = 1'h0, emcyGo = 1'h0, emcyZero = 1'h0;
  logic [7:0] paddr = 8'h0, txData0, txData1;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, txDlc;
  logic [10:0] txId, rxId;
  logic [63:0] rxData;
  logic [15:0] fault_code_word, warnStatus;
  logic [5:0] emcyNode = 6'h0;
  int miscompares = 0, checks_done = 0, mark, cnt;
  system_bus_master_control #(.TICK_CYCLES(TICK)) system_bus_master_control_inst (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .initDone, .localFault, .txValid, .txReady, .txId, .txDlc, .txData0,
    .txData1, .rxValid, .rxId, .rxData, .failure, .bus_fault_flag, .fault_code_word,
    .warnStatus);
  node_model node_model_inst (.mclk, .rst, .stall, .txValid, .txReady, .txId, .txData0,
    .txData1, .emcyGo, .emcyNode, .emcyZero, .rxValid, .rxId, .rxData);
  // Clock and watchdog.
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic emcy(input logic [5:0] n, input logic z);
    emcyNode <= n;
    emcyZero <= z;
    emcyGo <= 1'h1;
    @(posedge mclk);
    emcyGo <= 1'h0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic stat(input logic [1:0] ff, input logic [15:0] w, input logic [15:0] c);
    repeat (2) @(posedge mclk);
    check({14'h0, failure, bus_fault_flag, warnStatus}, {14'h0, ff, w});
    check({16'h0, fault_code_word}, {16'h0, c});
  endtask
  task automatic complete_run();
    $display("Checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    stat(2'h0, 16'h0, 16'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      check(rd, rows[i].exp);
      check({31'h0, err}, {31'h0, rows[i].e});
    end
    initDone <= 1'h1;
    mark = node_model_inst.cyc;
    apb(1'h1, 8'h04, 32'h5);
    repeat (100) @(posedge mclk);
    check(node_model_inst.syncGap, 5 * TICK);
    check({21'h0, node_model_inst.syncId}, 32'h80);
    apb(1'h1, 8'h08, 32'h123);  // Kept clear of emergency identifiers.
    repeat (50) @(posedge mclk);
    check({21'h0, node_model_inst.syncId}, 32'h123);
    stall <= 1'h1;
    repeat (30) @(posedge mclk);
    cnt = node_model_inst.syncCount;
    repeat (10) @(posedge mclk);
    check({31'h0, txValid}, 32'h1);
    check(node_model_inst.syncCount, cnt);
    stall <= 1'h0;
    apb(1'h1, 8'h04, 32'h0);
    repeat (30) @(posedge mclk);
    cnt = node_model_inst.syncCount;
    repeat (100) @(posedge mclk);
    check(node_model_inst.syncCount, cnt);
    check({30'h0, node_model_inst.nodeState}, 32'h0);
    while (node_model_inst.cyc - mark < 3499 * TICK - 10) @(posedge mclk);
    check(node_model_inst.startCount, 32'h0);
    for (int k = 0; k < 100 && node_model_inst.startCount == 0; k++) @(posedge mclk);
    check({30'h0, node_model_inst.nodeState}, 32'h1);
    repeat (3500 * TICK + 20) @(posedge mclk);
    check(node_model_inst.startCount, 32'h2);
    check(node_model_inst.startGap, 3500 * TICK);
    emcy(6'h05, 1'h0);
    stat(2'h3, 16'h2000, 16'h2105);
    emcy(6'h09, 1'h0);
    stat(2'h3, 16'h2000, 16'h2105);
    // Status, last reporting node and event count as software reads them.
    apb(1'h0, 8'h14, 32'h0);
    check(rd, 32'h7);
    apb(1'h0, 8'h20, 32'h0);
    check(rd, 32'h9);
    apb(1'h0, 8'h24, 32'h0);
    check(rd, 32'h2);
    apb(1'h1, 8'h10, 32'h1);
    stat(2'h0, 16'h0, 16'h0);
    emcy(6'h05, 1'h1);
    stat(2'h0, 16'h0, 16'h0);
    apb(1'h1, 8'h0c, 32'h1);
    emcy(6'h3f, 1'h0);
    stat(2'h1, 16'h2000, 16'h0);
    apb(1'h1, 8'h10, 32'h1);
    apb(1'h1, 8'h0c, 32'h2);
    emcy(6'h07, 1'h0);
    stat(2'h0, 16'h0, 16'h0);
    localFault <= 1'h1;
    @(posedge mclk);
    localFault <= 1'h0;
    stat(2'h3, 16'h0, 16'h0);
    apb(1'h1, 8'h10, 32'h1);
    stat(2'h0, 16'h0, 16'h0);
    // A reset in mid-run drops faults, frames and settings back to their reset values.
    apb(1'h1, 8'h04, 32'h5);
    localFault <= 1'h1;
    @(posedge mclk);
    localFault <= 1'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    stat(2'h0, 16'h0, 16'h0);
    check({31'h0, txValid}, 32'h0);
    check({30'h0, node_model_inst.nodeState}, 32'h0);
    apb(1'h0, 8'h04, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    check(rd, 32'h0);
    complete_run();
  end
endmodule
bind system_bus_master_control system_bus_master_control_sva system_bus_master_control_sva_inst (
  .mclk, .rst, .initDone, .localFault, .txValid, .txReady, .txId, .txDlc, .txData0,
  .txData1, .rxValid, .rxId, .rxData, .failure, .bus_fault_flag, .fault_code_word,
  .warnStatus);
